// [design/scs_pkg.sv]
// Purpose: shared constants for the system clock source select block
// Assumes: 32-bit AXI4-Lite register bus, one register per aligned word
// Notes:   field positions and reset values live here only
package scs_pkg;
	localparam int unsigned DATA_W = 32;
	localparam int unsigned ADDR_W = 4;

	localparam logic [3:0] CTRL_OFFSET   = 4'h0;
	localparam logic [3:0] PLLCFG_OFFSET = 4'h4;
	localparam logic [3:0] STATUS_OFFSET = 4'h8;

	localparam int unsigned SEL_LSB       = 0;
	localparam int unsigned BYPASS_BIT    = 2;
	localparam int unsigned OSC_INT_BIT   = 3;
	localparam int unsigned PLL_INPUT_DIVIDER_LSB      = 16;
	localparam int unsigned PLL_INPUT_DIVIDER_W        = 10;

	localparam int unsigned PLL_IN_LSB    = 0;
	localparam int unsigned PLL_IN_W      = 6;
	localparam int unsigned PLL_FB_LSB    = 8;
	localparam int unsigned PLL_FB_W      = 8;
	localparam int unsigned PLL_OUT_LSB   = 16;
	localparam int unsigned PLL_OUT_W     = 10;

	localparam int unsigned ST_SEL_LSB    = 0;
	localparam int unsigned ST_BYPASS_BIT = 2;
	localparam int unsigned ST_OSCINT_BIT = 3;
	localparam int unsigned ST_BUSY_BIT   = 4;
	localparam int unsigned ST_CLK_BIT    = 5;
	localparam int unsigned ST_PLL_INPUT_DIVIDER_LSB   = 16;

	localparam logic [31:0] CTRL_RESET   = 32'h0000_0000;
	localparam logic [31:0] PLLCFG_RESET = 32'h0000_0000;

	localparam logic [1:0] SEL_WAKEUP = 2'h0;
	localparam logic [1:0] SEL_PLLPRE = 2'h2;
	localparam logic [1:0] SEL_DIRECT = 2'h3;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// source vector indices
	localparam int unsigned SRC_DIRECT  = 0;
	localparam int unsigned SRC_CRYSTAL = 1;
	localparam int unsigned SRC_INTERNAL = 2;
	localparam int unsigned SRC_PLL     = 3;
	localparam int unsigned SRC_WAKEUP  = 4;
	localparam int unsigned SRC_N       = 5;

	typedef enum logic [2:0] {
		SW_RUN      = 3'h1,
		SW_PARK_OLD = 3'h2,
		SW_PARK_NEW = 3'h4
	} scs_switch_type;
endpackage

// [design/scs_prescaler.sv]
// Purpose: divides a sampled oscillator level by a programmable factor
// Assumes: osc_level is already synchronised to aclk
// Notes:   counts half periods, so factor 1 reproduces the source duty cycle
`timescale 1ns/10ps
`default_nettype none
module scs_prescaler #(
	parameter int unsigned DIV_W = 10
) (
	input  wire logic             aclk,
	input  wire logic             aresetn,
	input  wire logic             restart,
	input  wire logic             osc_level,
	input  wire logic [DIV_W-1:0] divider,
	output logic                  div_level
);
	logic             prev_reg;
	logic             armed_reg;
	logic [DIV_W+1:0] half_reg;
	logic [DIV_W+1:0] half_next;
	logic [DIV_W+1:0] factor;
	logic [DIV_W+1:0] last_half;
	wire              rise = osc_level & ~prev_reg;
	wire              edge_seen = osc_level ^ prev_reg;

	assign factor    = {2'h0, divider} + {{(DIV_W+1){1'b0}}, 1'b1};
	assign last_half = (factor << 1) - {{(DIV_W+1){1'b0}}, 1'b1};
	assign half_next = (half_reg == last_half) ? '0 : half_reg + {{(DIV_W+1){1'b0}}, 1'b1};

	always_ff @(posedge aclk) begin
		if (!aresetn || restart) begin
			prev_reg  <= 1'b0;
			armed_reg <= 1'b0;
			half_reg  <= '0;
			div_level <= 1'b0;
		end else begin
			prev_reg <= osc_level;
			if (!armed_reg) begin
				// align to a rising edge; prev_reg restarts low, so a level already high counts as one and the first high phase can be short
				if (rise) begin
					armed_reg <= 1'b1;
					half_reg  <= '0;
					div_level <= 1'b1;
				end
			end else if (edge_seen) begin
				half_reg  <= half_next;
				div_level <= (half_next < factor);
			end
		end
	end
endmodule
`default_nettype wire

// [design/scs_clock_select.sv]
// Purpose: system clock source selection with prescaler, behind AXI4-Lite
// Assumes: all clock sources are pins sampled on aclk, far slower than aclk
// Notes:   the system clock output is a registered level, switched only in low phases
// Function
// - select 11 passes the direct-drive clock through at its own frequency and duty cycle.
// - select 10 with bypass set divides the crystal or internal source by the prescaler.
// - the prescaler divides by the programmed divider value plus one.
// - the divider reaches a factor of 1024 at its largest value.
// - a factor of one passes the oscillator unchanged with its own duty cycle.
// - select 10 with bypass clear takes the PLL output, configured by its three dividers.
// - select 00 runs the system clock from the wakeup source.
`timescale 1ns/10ps
`default_nettype none
module scs_clock_select #(
	parameter int unsigned PLL_INPUT_DIVIDER_W = scs_pkg::PLL_INPUT_DIVIDER_W
) (
	input  wire logic                          aclk,
	input  wire logic                          aresetn,
	input  wire logic [scs_pkg::ADDR_W-1:0]    s_axi_awaddr,
	input  wire logic [2:0]                    s_axi_awprot,
	input  wire logic                          s_axi_awvalid,
	output logic                               s_axi_awready,
	input  wire logic [scs_pkg::DATA_W-1:0]    s_axi_wdata,
	input  wire logic [3:0]                    s_axi_wstrb,
	input  wire logic                          s_axi_wvalid,
	output logic                               s_axi_wready,
	output logic [1:0]                         s_axi_bresp,
	output logic                               s_axi_bvalid,
	input  wire logic                          s_axi_bready,
	input  wire logic [scs_pkg::ADDR_W-1:0]    s_axi_araddr,
	input  wire logic [2:0]                    s_axi_arprot,
	input  wire logic                          s_axi_arvalid,
	output logic                               s_axi_arready,
	output logic [scs_pkg::DATA_W-1:0]         s_axi_rdata,
	output logic [1:0]                         s_axi_rresp,
	output logic                               s_axi_rvalid,
	input  wire logic                          s_axi_rready,
	input  wire logic                          direct_drive_clock_input,
	input  wire logic                          crystal_input,
	input  wire logic                          internal_clock_input,
	input  wire logic                          pll_clock_input,
	input  wire logic                          wakeup_clock_input,
	output logic [scs_pkg::PLL_IN_W-1:0]       pll_input_divider,
	output logic [scs_pkg::PLL_FB_W-1:0]       pll_feedback_divider,
	output logic [scs_pkg::PLL_OUT_W-1:0]      pll_output_divider,
	output logic                               system_clock
);
	logic [31:0]                  ctrl_reg;
	logic [31:0]                  pllcfg_reg;
	logic [scs_pkg::SRC_N-1:0]    meta_reg;
	logic [scs_pkg::SRC_N-1:0]    sync_reg;
	logic [1:0]                   act_sel_reg;
	logic                         act_bypass_reg;
	logic                         act_oscint_reg;
	logic [PLL_INPUT_DIVIDER_W-1:0]            act_pll_input_divider_reg;
	logic                         restart_reg;
	scs_pkg::scs_switch_type      sw_reg;
	scs_pkg::scs_switch_type      sw_next;
	logic                         div_level;
	logic                         src_level;
	logic                         clk_next;

	// sampled sources; only the second stage is read by logic
	wire [scs_pkg::SRC_N-1:0] src_pins = {wakeup_clock_input, pll_clock_input,
		internal_clock_input, crystal_input, direct_drive_clock_input};

	genvar gi;
	generate
		for (gi = 0; gi < scs_pkg::SRC_N; gi++) begin : g_sync
			always_ff @(posedge aclk) begin
				if (!aresetn) begin
					meta_reg[gi] <= 1'b0;
					sync_reg[gi] <= 1'b0;
				end else begin
					meta_reg[gi] <= src_pins[gi];
					sync_reg[gi] <= meta_reg[gi];
				end
			end
		end
	endgenerate

	// requested configuration fields
	wire [1:0]        req_sel    = ctrl_reg[scs_pkg::SEL_LSB +: 2];
	wire              req_bypass = ctrl_reg[scs_pkg::BYPASS_BIT];
	wire              req_oscint = ctrl_reg[scs_pkg::OSC_INT_BIT];
	wire [PLL_INPUT_DIVIDER_W-1:0] req_pll_input_divider   = ctrl_reg[scs_pkg::PLL_INPUT_DIVIDER_LSB +: PLL_INPUT_DIVIDER_W];
	wire              cfg_change = (req_sel != act_sel_reg) || (req_bypass != act_bypass_reg)
		|| (req_oscint != act_oscint_reg) || (req_pll_input_divider != act_pll_input_divider_reg);

	wire osc_level = act_oscint_reg ? sync_reg[scs_pkg::SRC_INTERNAL]
		: sync_reg[scs_pkg::SRC_CRYSTAL];

	scs_prescaler #(
		.DIV_W (PLL_INPUT_DIVIDER_W)
	) u_prescaler (
		.aclk      (aclk),
		.aresetn   (aresetn),
		.restart   (restart_reg),
		.osc_level (osc_level),
		.divider   (act_pll_input_divider_reg),
		.div_level (div_level)
	);

	always_comb begin
		unique case (act_sel_reg)
			scs_pkg::SEL_DIRECT: src_level = sync_reg[scs_pkg::SRC_DIRECT];
			scs_pkg::SEL_PLLPRE: src_level = act_bypass_reg ? div_level
				: sync_reg[scs_pkg::SRC_PLL];
			scs_pkg::SEL_WAKEUP: src_level = sync_reg[scs_pkg::SRC_WAKEUP];
			default:             src_level = 1'b0;
		endcase
	end

	// a change waits for the running clock to be low, then holds low until
	// the new source is low too, so no phase is cut short, except the first prescaler high when the oscillator is already high at restart
	always_comb begin
		sw_next  = sw_reg;
		clk_next = 1'b0;
		unique case (sw_reg)
			scs_pkg::SW_RUN: begin
				clk_next = src_level;
				if (cfg_change) begin
					sw_next = scs_pkg::SW_PARK_OLD;
				end
			end
			scs_pkg::SW_PARK_OLD: begin
				clk_next = src_level;
				if (!src_level && !system_clock) begin
					clk_next = 1'b0;
					sw_next  = scs_pkg::SW_PARK_NEW;
				end
			end
			scs_pkg::SW_PARK_NEW: begin
				if (!restart_reg && !src_level) begin
					sw_next = scs_pkg::SW_RUN;
				end
			end
			default: sw_next = scs_pkg::SW_RUN;
		endcase
	end

	wire take_cfg = (sw_reg == scs_pkg::SW_PARK_OLD) && (sw_next == scs_pkg::SW_PARK_NEW);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sw_reg         <= scs_pkg::SW_RUN;
			system_clock   <= 1'b0;
			act_sel_reg    <= scs_pkg::CTRL_RESET[scs_pkg::SEL_LSB +: 2];
			act_bypass_reg <= scs_pkg::CTRL_RESET[scs_pkg::BYPASS_BIT];
			act_oscint_reg <= scs_pkg::CTRL_RESET[scs_pkg::OSC_INT_BIT];
			act_pll_input_divider_reg   <= scs_pkg::CTRL_RESET[scs_pkg::PLL_INPUT_DIVIDER_LSB +: PLL_INPUT_DIVIDER_W];
			restart_reg    <= 1'b0;
		end else begin
			sw_reg       <= sw_next;
			system_clock <= clk_next;
			restart_reg  <= take_cfg;
			if (take_cfg) begin
				act_sel_reg    <= req_sel;
				act_bypass_reg <= req_bypass;
				act_oscint_reg <= req_oscint;
				act_pll_input_divider_reg   <= req_pll_input_divider;
			end
		end
	end

	// the PLL macro takes its dividers straight from the register
	assign pll_input_divider    = pllcfg_reg[scs_pkg::PLL_IN_LSB +: scs_pkg::PLL_IN_W];
	assign pll_feedback_divider = pllcfg_reg[scs_pkg::PLL_FB_LSB +: scs_pkg::PLL_FB_W];
	assign pll_output_divider   = pllcfg_reg[scs_pkg::PLL_OUT_LSB +: scs_pkg::PLL_OUT_W];

	// write channel: address and data are taken together
	wire        wr_go    = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
	wire        wr_ctrl  = wr_go && (s_axi_awaddr == scs_pkg::CTRL_OFFSET);
	wire        wr_pll   = wr_go && (s_axi_awaddr == scs_pkg::PLLCFG_OFFSET);
	wire        wr_stat  = wr_go && (s_axi_awaddr == scs_pkg::STATUS_OFFSET);
	wire [31:0] wmask    = {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}},
		{8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};

	assign s_axi_awready = wr_go;
	assign s_axi_wready  = wr_go;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_reg     <= scs_pkg::CTRL_RESET;
			pllcfg_reg   <= scs_pkg::PLLCFG_RESET;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= scs_pkg::RESP_OKAY;
		end else begin
			if (wr_ctrl) begin
				ctrl_reg <= (ctrl_reg & ~wmask) | (s_axi_wdata & wmask);
			end
			if (wr_pll) begin
				pllcfg_reg <= (pllcfg_reg & ~wmask) | (s_axi_wdata & wmask);
			end
			if (wr_go) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= (wr_ctrl || wr_pll || wr_stat) ? scs_pkg::RESP_OKAY
					: scs_pkg::RESP_SLVERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// read channel
	wire        rd_go = s_axi_arvalid && !s_axi_rvalid;
	wire [31:0] status_word;
	assign status_word = {{(16-PLL_INPUT_DIVIDER_W){1'b0}}, act_pll_input_divider_reg, 10'h000, system_clock,
		(sw_reg != scs_pkg::SW_RUN), act_oscint_reg, act_bypass_reg, act_sel_reg};

	wire        rd_ctrl = (s_axi_araddr == scs_pkg::CTRL_OFFSET);
	wire        rd_pll  = (s_axi_araddr == scs_pkg::PLLCFG_OFFSET);
	wire        rd_stat = (s_axi_araddr == scs_pkg::STATUS_OFFSET);
	wire [31:0] rd_word = rd_ctrl ? ctrl_reg : rd_pll ? pllcfg_reg
		: rd_stat ? status_word : 32'h0000_0000;

	assign s_axi_arready = rd_go;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
			s_axi_rresp  <= scs_pkg::RESP_OKAY;
		end else if (rd_go) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= rd_word;
			s_axi_rresp  <= (rd_ctrl || rd_pll || rd_stat) ? scs_pkg::RESP_OKAY
				: scs_pkg::RESP_SLVERR;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// [dv/scs_props.sv]
// Purpose: bus handshake and clock pulse checks for the clock select block
// Assumes: bound to scs_clock_select, sources hold each phase >= 3 cycles
// Notes:   pulse checks are minimum widths, exact widths are measured by the bench
`timescale 1ns/10ps
`default_nettype none
module scs_props (
	input wire logic                          aclk,
	input wire logic                          aresetn,
	input wire logic                          s_axi_awvalid,
	input wire logic                          s_axi_awready,
	input wire logic                          s_axi_wready,
	input wire logic                          s_axi_bvalid,
	input wire logic                          s_axi_bready,
	input wire logic [1:0]                    s_axi_bresp,
	input wire logic                          s_axi_arvalid,
	input wire logic                          s_axi_arready,
	input wire logic                          s_axi_rvalid,
	input wire logic                          s_axi_rready,
	input wire logic [scs_pkg::DATA_W-1:0]    s_axi_rdata,
	input wire logic [scs_pkg::PLL_IN_W-1:0]  pll_input_divider,
	input wire logic [scs_pkg::PLL_FB_W-1:0]  pll_feedback_divider,
	input wire logic [scs_pkg::PLL_OUT_W-1:0] pll_output_divider,
	input wire logic                          system_clock
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence high_rest;
		system_clock [*2];
	endsequence
	sequence low_rest;
		!system_clock;
	endsequence
	a_write_answer: assert property (s_axi_awvalid && s_axi_awready |=> s_axi_bvalid)
		else $error("write response late");
	a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready |=>
		s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read response late");
	a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
	a_write_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken while response pending");
	a_read_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while response pending");
	a_high_full: assert property ($rose(system_clock) |=> high_rest)
		else $error("short high pulse");
	a_low_full: assert property ($fell(system_clock) |=> low_rest)
		else $error("short low pulse");
	a_pll_steady: assert property (!(s_axi_awvalid && s_axi_awready) |=>
		$stable({pll_input_divider, pll_feedback_divider, pll_output_divider}))
		else $error("pll dividers moved without a write");
endmodule
bind scs_clock_select scs_props scs_props_i (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
	.s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready,
	.s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .pll_input_divider, .pll_feedback_divider,
	.pll_output_divider, .system_clock);
`default_nettype wire

// [dv/tb_top.sv]
// Purpose: self-checking bench for the clock select block
// Assumes: sources made here from one counter, every phase >= 3 cycles
// Notes:   pulse widths counted in aclk cycles; one period skipped after each switch
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	logic        aclk = 1'h0, aresetn = 1'h0;
	logic [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
	logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
	logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic        direct_drive_clock_input = 1'h0, crystal_input = 1'h0;
	logic        internal_clock_input = 1'h0, pll_clock_input = 1'h0;
	logic        wakeup_clock_input = 1'h0, system_clock;
	logic [5:0]  pll_input_divider;
	logic [7:0]  pll_feedback_divider;
	logic [9:0]  pll_output_divider;
	int          src_cnt = 0, num_errors = 0, checks = 0;
	always #50 aclk = ~aclk;
	// unequal periods so a wrong selection shows as a wrong width
	always @(posedge aclk) begin
		src_cnt <= src_cnt + 1;
		direct_drive_clock_input <= (src_cnt % 14) < 4;
		crystal_input <= (src_cnt % 10) < 5;
		internal_clock_input <= (src_cnt % 9) < 3;
		pll_clock_input <= (src_cnt % 8) < 4;
		wakeup_clock_input <= (src_cnt % 18) < 9;
	end
	scs_clock_select scs_clock_select_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'h0),
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .direct_drive_clock_input, .crystal_input,
		.internal_clock_input, .pll_clock_input, .wakeup_clock_input, .pll_input_divider,
		.pll_feedback_divider, .pll_output_divider, .system_clock);
	task automatic stop_test();
		if (num_errors == 0 && checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	task automatic chk(string name, logic [31:0] exp, logic [31:0] got);
		checks++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected %s: expected %0h, seen %0h", name, exp, got);
		end
	endtask
	task automatic step(inout int n);
		@(posedge aclk);
		n++;
		if (n > 40000) begin
			num_errors++;
			$display("unexpected wait: expected at most 40000 cycles, seen %0d", n);
			stop_test();
		end
	endtask
	task automatic axi_write(logic [3:0] a, logic [31:0] d, logic [1:0] resp);
		int n = 0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		do step(n); while (s_axi_awready !== 1'h1 || s_axi_wready !== 1'h1);
		s_axi_awvalid <= 1'h0;
		s_axi_wvalid <= 1'h0;
		s_axi_bready <= 1'h1;
		do step(n); while (s_axi_bvalid !== 1'h1);
		s_axi_bready <= 1'h0;
		chk("bresp", {30'h0, resp}, {30'h0, s_axi_bresp});
	endtask
	task automatic axi_read(logic [3:0] a, logic [31:0] mask, logic [31:0] exp, logic [1:0] resp);
		int n = 0;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		do step(n); while (s_axi_arready !== 1'h1);
		s_axi_arvalid <= 1'h0;
		s_axi_rready <= 1'h1;
		do step(n); while (s_axi_rvalid !== 1'h1);
		s_axi_rready <= 1'h0;
		chk("rdata", exp, s_axi_rdata & mask);
		chk("rresp", {30'h0, resp}, {30'h0, s_axi_rresp});
	endtask
	task automatic measure(int hi, int lo);
		int n = 0;
		int h = 0;
		int l = 0;
		do step(n); while (system_clock !== 1'h0);
		do step(n); while (system_clock !== 1'h1);
		do step(n); while (system_clock !== 1'h0);
		do step(n); while (system_clock !== 1'h1);
		while (system_clock === 1'h1) begin
			h++;
			step(n);
		end
		while (system_clock === 1'h0) begin
			l++;
			step(n);
		end
		chk("high cycles", hi, h);
		chk("low cycles", lo, l);
	endtask
	task automatic check_reset();
		axi_read(4'h0, 32'hFFFF_FFFF, 32'h0, 2'h0);
		axi_read(4'h4, 32'hFFFF_FFFF, 32'h0, 2'h0);
		axi_read(4'h8, 32'h03FF_001F, 32'h0, 2'h0);
		measure(9, 9);
	endtask
	task automatic check_direct();
		axi_write(4'h0, 32'h0000_0003, 2'h0);
		measure(4, 10);
		axi_read(4'h8, 32'h0000_001F, 32'h0000_0003, 2'h0);
	endtask
	task automatic check_prescale_one();
		axi_write(4'h0, 32'h0000_000E, 2'h0);
		measure(3, 6);
	endtask
	task automatic check_prescale_three();
		axi_write(4'h0, 32'h0002_0006, 2'h0);
		measure(15, 15);
		axi_read(4'h8, 32'h03FF_001F, 32'h0002_0006, 2'h0);
	endtask
	task automatic check_prescale_max();
		axi_write(4'h0, 32'h03FF_0006, 2'h0);
		// the switch needs at least three cycles, so busy still stands here
		axi_read(4'h8, 32'h0000_0010, 32'h0000_0010, 2'h0);
		measure(5120, 5120);
	endtask
	task automatic check_select_unused();
		int n = 0;
		int hi = 0;
		axi_write(4'h0, 32'h0000_0001, 2'h0);
		// let the old PLL phase finish and the switch complete
		repeat (20) step(n);
		repeat (40) begin
			step(n);
			if (system_clock !== 1'h0) hi++;
		end
		chk("high cycles", 32'h0, hi);
	endtask
	task automatic check_pll();
		axi_write(4'h4, 32'h0203_0405, 2'h0);
		chk("pll in", 32'h5, {26'h0, pll_input_divider});
		chk("pll fb", 32'h4, {24'h0, pll_feedback_divider});
		chk("pll out", 32'h203, {22'h0, pll_output_divider});
		axi_write(4'h0, 32'h0000_0002, 2'h0);
		measure(4, 4);
	endtask
	task automatic check_wakeup();
		axi_write(4'h0, 32'h0000_0000, 2'h0);
		measure(9, 9);
	endtask
	task automatic check_bus_errors();
		axi_write(4'hC, 32'h0000_0001, 2'h2);
		axi_read(4'hC, 32'hFFFF_FFFF, 32'h0, 2'h2);
		axi_write(4'h8, 32'hFFFF_FFFF, 2'h0);
		axi_read(4'h0, 32'hFFFF_FFFF, 32'h0, 2'h0);
	endtask
	initial begin
		repeat (6) @(posedge aclk);
		aresetn <= 1'h1;
		check_reset();
		check_direct();
		check_prescale_one();
		check_prescale_three();
		check_prescale_max();
		check_pll();
		check_select_unused();
		check_wakeup();
		check_bus_errors();
		stop_test();
	end
endmodule
`default_nettype wire
